// file: dv/core_model.sv
`timescale 1ns/1ps
module core_model
    import exc_irq_pkg::*;
(
    output logic [15:0] o_psw,
    output logic [2:0]  o_src_req,
    output exc_event_s  o_event
);
    initial begin
        o_psw = 16'h0000;
        o_src_req = 3'h0;
        o_event = '0;
    end
    // caller sits just after a rising edge
    task automatic drive(input logic [15:0] p, input logic [2:0] r, input logic [4:0] e);
        o_psw <= p;
        o_src_req <= r;
        o_event <= e;
    endtask
    // reserved bits never written as one
    function automatic logic [7:0] hi_val(input logic en, input logic typ);
        return {3'h0, en, 1'b0, typ, 2'h0};
    endfunction
    // flags only go away by writing zero over them
    function automatic logic [7:0] lo_clear(input logic [7:0] v);
        return v & LO_EN_BITS;
    endfunction
endmodule

// file: dv/exception_irq_control_tb_top.sv
`timescale 1ns/1ps
module exception_irq_control_tb_top
    import exc_irq_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0;
    wire         awr, wr, bv, arr, rv, exc, osc, irq;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rd;
    wire [2:0]   acc, sreq;
    wire [15:0]  program_status_word;
    wire exc_event_s ev;
    int          err_count = 0, tests_run = 0, cyc = 0;
    integer      seed = 32'hD28F71D4;
    logic [15:0] rmap [5] = '{IDX_LEVEL, IDX_EXC_LO, IDX_EXC_HI, IDX_STAT, IDX_MASK};
    int          fb [4] = '{7, 5, 3, 1};
    logic [5:0]  lv;
    logic [15:0] p;
    logic [2:0]  rq, e;
    logic [7:0]  x;

    always #2 clk = ~clk;

    exception_irq_control i_exception_irq_control (
        .I_SYS_CLK(clk), .I_RESET(rst), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
        .I_WVALID(wv), .O_WREADY(wr), .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv),
        .I_BREADY(br), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
        .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rd), .O_RRESP(rresp), .I_PSW(program_status_word),
        .I_EVENT(ev), .I_SRC_REQ(sreq), .O_SRC_ACCEPT(acc), .O_EXC_REQ(exc),
        .O_OSC_DETECT_EN(osc), .O_IRQ(irq));

    core_model i_core_model (.o_psw(program_status_word), .o_src_req(sreq), .o_event(ev));

    task automatic chk(input string n, input logic [31:0] x_e, input logic [31:0] x_s);
        tests_run++;
        if (x_s !== x_e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, x_e, x_s);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // address and data offered together, bready held until the answer
    task automatic axw(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= {14'h0, idx, 2'h0};
        wd <= {24'h0, d};
        br <= 1'b1;
        do @(posedge clk); while (awr !== 1'b1 || wr !== 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        while (bv !== 1'b1) @(posedge clk);
        chk("bresp", er, bresp);
        br <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        arv <= 1'b1;
        ara <= {14'h0, idx, 2'h0};
        rr <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge clk);
        chk("rdata", {24'h0, d}, rd);
        chk("rresp", er, rresp);
        rr <= 1'b0;
        @(posedge clk);
    endtask

    // one-cycle event pulse, status word held
    task automatic evp(input logic [4:0] v);
        i_core_model.drive(p, 3'h0, v);
        @(posedge clk);
        i_core_model.drive(p, 3'h0, 5'h0);
        @(posedge clk);
    endtask

    // generous ceiling: the sequence needs a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rmap[k]) axr(rmap[k], 8'h00, RESP_OKAY);
        for (int k = 0; k < 24; k++) begin
            lv = 6'($random(seed));
            p = 16'($random(seed));
            rq = 3'($random(seed));
            axw(IDX_LEVEL, {2'h0, lv}, RESP_OKAY);
            axr(IDX_LEVEL, {2'h0, lv}, RESP_OKAY);
            i_core_model.drive(p, rq, 5'h0);
            @(posedge clk);
            for (int s = 0; s < 3; s++) e[s] = rq[s] & p[PSW_IE] & (lv[2*s +: 2] > p[10:8]);
            chk("accept", e, acc);
        end
        p = 16'h0880;
        i_core_model.drive(p, 3'h0, 5'h0);
        axw(IDX_MASK, 8'h1F, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            axw(IDX_EXC_LO, 8'hFF, RESP_OKAY);
            chk("osc_en", 1, osc);
            evp(5'(1 << i));
            x = 8'h55 | 8'(1 << fb[i]);
            axr(IDX_EXC_LO, x, RESP_OKAY);
            chk("exc_req", 1, exc);
            chk("irq", 1, irq);
            i_core_model.drive(16'h0800, 3'h0, 5'h0);
            @(posedge clk);
            chk("exc_req_noie", 0, exc);
            i_core_model.drive(p, 3'h0, 5'h0);
            axr(IDX_STAT, 8'(1 << i), RESP_OKAY);
            chk("irq_after_read", 0, irq);
            axw(IDX_EXC_LO, i_core_model.lo_clear(x), RESP_OKAY);
            axr(IDX_EXC_LO, 8'h55, RESP_OKAY);
            chk("exc_req_clr", 0, exc);
        end
        axw(IDX_MASK, 8'h00, RESP_OKAY);
        evp(5'h02);
        chk("irq_masked", 0, irq);
        axr(IDX_STAT, 8'h02, RESP_OKAY);
        axw(IDX_EXC_LO, 8'h15, RESP_OKAY);
        chk("osc_off", 0, osc);
        evp(5'h01);
        axr(IDX_EXC_LO, 8'h15, RESP_OKAY);
        i_core_model.drive(16'h0080, 3'h0, 5'h0);
        axw(IDX_EXC_LO, 8'hFF, RESP_OKAY);
        axw(IDX_EXC_HI, 8'h14, RESP_OKAY);
        axr(IDX_EXC_LO, 8'h15, RESP_OKAY);
        axr(IDX_EXC_HI, 8'h00, RESP_OKAY);
        i_core_model.drive(p, 3'h0, 5'h02);
        axw(IDX_EXC_LO, 8'h10, RESP_OKAY);
        i_core_model.drive(p, 3'h0, 5'h00);
        axr(IDX_EXC_LO, 8'h30, RESP_OKAY);
        axw(IDX_EXC_HI, i_core_model.hi_val(1'b1, 1'b1), RESP_OKAY);
        i_core_model.drive(16'h0800, 3'h0, 5'h10);
        repeat (2) @(posedge clk);
        chk("ser_gated", 0, exc);
        axr(IDX_EXC_HI, 8'h34, RESP_OKAY);
        axw(IDX_EXC_HI, i_core_model.hi_val(1'b1, 1'b0), RESP_OKAY);
        chk("ser_ungated", 1, exc);
        i_core_model.drive(16'h0800, 3'h0, 5'h00);
        axw(IDX_EXC_HI, 8'h20 | i_core_model.hi_val(1'b1, 1'b0), RESP_OKAY);
        axr(IDX_EXC_HI, 8'h10, RESP_OKAY);
        axw(16'h7F00, 8'h01, RESP_SLVERR);
        axr(16'h7F00, 8'h00, RESP_SLVERR);
        close_out();
    end
endmodule

// file: hw/exc_irq_pkg.sv
package exc_irq_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_LEVEL  = 16'h7F05;
    localparam logic [15:0] IDX_EXC_LO = 16'h7F08;
    localparam logic [15:0] IDX_EXC_HI = 16'h7F09;
    localparam logic [15:0] IDX_STAT   = 16'h7F10;
    localparam logic [15:0] IDX_MASK   = 16'h7F11;

    // level register fields (low bit of each pair)
    localparam int LVL_8038_LO = 4;
    localparam int LVL_8034_LO = 2;
    localparam int LVL_8030_LO = 0;

    // low exception register fields
    localparam int LO_CLK_FLG = 7;
    localparam int LO_CLK_EN  = 6;
    localparam int LO_ADR_FLG = 5;
    localparam int LO_ODD_FLG = 3;
    localparam int LO_BAD_FLG = 1;
    localparam logic [7:0] LO_FLG_BITS = 8'hAA;
    localparam logic [7:0] LO_EN_BITS  = 8'h55;

    // high exception register fields
    localparam int HI_SER_FLG  = 5;
    localparam int HI_SER_EN   = 4;
    localparam int HI_SER_TYPE = 2;

    // program status word fields
    localparam int PSW_PERMIT = 11;
    localparam int PSW_IE     = 7;
    localparam int PSW_LVL_LO = 8;

    localparam logic [5:0] RST_LEVEL  = 6'h00;
    localparam logic [7:0] RST_EXC_LO = 8'h00;
    localparam logic [4:0] RST_STAT   = 5'h00;
    localparam logic [4:0] RST_MASK   = 5'h00;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // first member is the top bit: clock_stop lands at bit 0
    typedef struct packed {
        logic serial0_req;
        logic illegal_op;
        logic misaligned;
        logic addr_err;
        logic clock_stop;
    } exc_event_s;

endpackage

// file: hw/exception_irq_control.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module exception_irq_control
    import exc_irq_pkg::*;
(
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RESET,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_AWADDR,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    output logic [1:0]       O_BRESP,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    input  wire logic [31:0] I_ARADDR,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    input  wire logic [15:0] I_PSW,
    input  wire exc_event_s  I_EVENT,
    input  wire logic [2:0]  I_SRC_REQ,
    output logic [2:0]       O_SRC_ACCEPT,
    output logic             O_EXC_REQ,
    output logic             O_OSC_DETECT_EN,
    output logic             O_IRQ
);

    function automatic logic [15:0] reg_idx(input logic [31:0] addr);
        reg_idx = addr[17:2];
    endfunction

    function automatic logic mapped(input logic [31:0] addr);
        logic [15:0] idx;
        idx = reg_idx(addr);
        mapped = (addr[31:18] == 14'h0000) &&
                 (idx == IDX_LEVEL || idx == IDX_EXC_LO || idx == IDX_EXC_HI ||
                  idx == IDX_STAT || idx == IDX_MASK);
    endfunction

    // a disabled source (code 00) is never above any current level
    function automatic logic above(input logic [1:0] lvl, input logic [2:0] cur);
        above = {1'b0, lvl} > cur;
    endfunction

    logic [5:0]  lvl_q;
    logic [5:0]  lvl_d;
    logic [7:0]  exc_lo_q;
    logic [7:0]  exc_lo_d;
    logic        ser_en_q;
    logic        ser_en_d;
    logic        ser_type_q;
    logic        ser_type_d;
    logic [4:0]  stat_q;
    logic [4:0]  stat_d;
    logic [4:0]  mask_q;
    logic [4:0]  mask_d;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    wire         wr_go    = I_AWVALID & I_WVALID & ~bvalid_q;
    wire [15:0]  wr_idx   = reg_idx(I_AWADDR);
    wire         wr_ok    = mapped(I_AWADDR);
    wire         wr_lane  = wr_go & wr_ok & I_WSTRB[0];
    wire         permit   = I_PSW[PSW_PERMIT];
    wire         wr_lo_rq = wr_lane & (wr_idx == IDX_EXC_LO);
    wire         wr_hi_rq = wr_lane & (wr_idx == IDX_EXC_HI);
    wire         wr_lo    = wr_lo_rq & permit;
    wire         wr_hi    = wr_hi_rq & permit;
    wire         wr_lvl   = wr_lane & (wr_idx == IDX_LEVEL);
    wire         wr_mask  = wr_lane & (wr_idx == IDX_MASK);
    wire         ar_go    = I_ARVALID & ~rvalid_q;
    wire [15:0]  rd_idx   = reg_idx(I_ARADDR);
    wire         rd_ok    = mapped(I_ARADDR);
    wire         rd_stat  = ar_go & rd_ok & (rd_idx == IDX_STAT);
    wire         ie       = I_PSW[PSW_IE];
    wire [2:0]   cur_lvl  = I_PSW[PSW_LVL_LO +: 3];

    // hardware flag sets
    wire set_clk = I_EVENT.clock_stop & exc_lo_q[LO_CLK_EN];
    wire set_adr = I_EVENT.addr_err;
    wire set_odd = I_EVENT.misaligned;
    wire set_bad = I_EVENT.illegal_op;
    wire [7:0] lo_set = {set_clk, 1'b0, set_adr, 1'b0, set_odd, 1'b0, set_bad, 1'b0};

    // writing 1 to a flag keeps it, 0 clears it; software can never set one
    wire [7:0] lo_wr_val = (I_WDATA[7:0] & LO_EN_BITS) |
                           (I_WDATA[7:0] & exc_lo_q & LO_FLG_BITS);
    assign exc_lo_d = (wr_lo ? lo_wr_val : exc_lo_q) | lo_set;

    // reserved high bits are not stored, so stray ones cannot act
    assign ser_en_d   = wr_hi ? I_WDATA[HI_SER_EN] : ser_en_q;
    assign ser_type_d = wr_hi ? I_WDATA[HI_SER_TYPE] : ser_type_q;
    assign lvl_d      = wr_lvl ? I_WDATA[5:0] : lvl_q;
    assign mask_d     = wr_mask ? I_WDATA[4:0] : mask_q;

    // status: sticky, read clears, a same-cycle event survives the read
    wire [4:0] ev_vec = {I_EVENT.serial0_req, set_bad, set_odd, set_adr, set_clk};
    assign stat_d = (rd_stat ? RST_STAT : stat_q) | ev_vec;

    // each flag sits one bit above its enable
    wire core_exc = |(exc_lo_q & {exc_lo_q[6:0], 1'b0} & LO_FLG_BITS);
    wire ser_exc  = ser_en_q & I_EVENT.serial0_req;
    assign O_EXC_REQ = (core_exc & ie) | (ser_exc & (~ser_type_q | ie));

    assign O_SRC_ACCEPT[0] = I_SRC_REQ[0] & ie &
                             above(lvl_q[LVL_8030_LO +: 2], cur_lvl);
    assign O_SRC_ACCEPT[1] = I_SRC_REQ[1] & ie &
                             above(lvl_q[LVL_8034_LO +: 2], cur_lvl);
    assign O_SRC_ACCEPT[2] = I_SRC_REQ[2] & ie &
                             above(lvl_q[LVL_8038_LO +: 2], cur_lvl);

    assign O_OSC_DETECT_EN = exc_lo_q[LO_CLK_EN];
    assign O_IRQ           = |(stat_q & mask_q);

    wire [7:0] hi_view = {2'b00, I_EVENT.serial0_req, ser_en_q,
                          1'b0, ser_type_q, 2'b00};
    wire [31:0] rd_word =
        !rd_ok                  ? 32'h0000_0000 :
        (rd_idx == IDX_LEVEL)   ? {26'h0, lvl_q} :
        (rd_idx == IDX_EXC_LO)  ? {24'h0, exc_lo_q} :
        (rd_idx == IDX_EXC_HI)  ? {24'h0, hi_view} :
        (rd_idx == IDX_STAT)    ? {27'h0, stat_q} :
                                  {27'h0, mask_q};

    assign O_AWREADY = wr_go;
    assign O_WREADY  = wr_go;
    assign O_BVALID  = bvalid_q;
    assign O_BRESP   = bresp_q;
    assign O_ARREADY = ~rvalid_q;
    assign O_RVALID  = rvalid_q;
    assign O_RDATA   = rdata_q;
    assign O_RRESP   = rresp_q;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            lvl_q      <= RST_LEVEL;
            exc_lo_q   <= RST_EXC_LO;
            ser_en_q   <= 1'b0;
            ser_type_q <= 1'b0;
            stat_q     <= RST_STAT;
            mask_q     <= RST_MASK;
        end else begin
            lvl_q      <= lvl_d;
            exc_lo_q   <= exc_lo_d;
            ser_en_q   <= ser_en_d;
            ser_type_q <= ser_type_d;
            stat_q     <= stat_d;
            mask_q     <= mask_d;
        end
    end

    // locked writes still answer OKAY; software sees no bus error
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (I_BREADY) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (ar_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (I_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RESET);

    property p_lvl_8038;
        (I_SRC_REQ[2] && ie && lvl_q[5:4] == 2'h3 && cur_lvl == 3'h2) |-> O_SRC_ACCEPT[2];
    endproperty
    a_lvl_8038: assert property (p_lvl_8038) else $error("8038 level 3 not accepted");

    property p_lvl_8034_off;
        (lvl_q[3:2] == 2'h0) |-> !O_SRC_ACCEPT[1];
    endproperty
    a_lvl_8034_off: assert property (p_lvl_8034_off) else $error("disabled 8034 accepted");

    property p_lvl_8030_low;
        (lvl_q[1:0] == 2'h1 && cur_lvl >= 3'h1) |-> !O_SRC_ACCEPT[0];
    endproperty
    a_lvl_8030_low: assert property (p_lvl_8030_low) else $error("8030 level too low");

    property p_locked;
        (wr_lo_rq && !permit && I_EVENT == 5'h00) |=>
            (exc_lo_q == $past(exc_lo_q));
    endproperty
    a_locked: assert property (p_locked) else $error("locked write changed register");

    property p_clk_set;
        (I_EVENT.clock_stop && exc_lo_q[LO_CLK_EN]) |=> exc_lo_q[LO_CLK_FLG];
    endproperty
    a_clk_set: assert property (p_clk_set) else $error("clock stop flag not set");

    property p_clk_idle;
        (!exc_lo_q[LO_CLK_EN] && !exc_lo_q[LO_CLK_FLG] && !wr_lo) |=> !exc_lo_q[LO_CLK_FLG];
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("clock stop flag set while off");

    property p_ev_set;
        (set_adr || set_odd || set_bad) |=>
            ((exc_lo_q & {2'b00, $past(set_adr), 1'b0, $past(set_odd), 1'b0,
                          $past(set_bad), 1'b0}) ==
             {2'b00, $past(set_adr), 1'b0, $past(set_odd), 1'b0, $past(set_bad), 1'b0});
    endproperty
    a_ev_set: assert property (p_ev_set) else $error("event flag not set");

    property p_hold;
        !wr_lo |=> (($past(exc_lo_q) & ~exc_lo_q & LO_FLG_BITS) == 8'h00);
    endproperty
    a_hold: assert property (p_hold) else $error("flag cleared by hardware");

    property p_exc_req;
        (exc_lo_q[LO_ADR_FLG] && exc_lo_q[LO_ADR_FLG-1] && ie) |-> O_EXC_REQ;
    endproperty
    a_exc_req: assert property (p_exc_req) else $error("exception request missing");

    property p_ser_ro;
        (ar_go && rd_ok && rd_idx == IDX_EXC_HI) |=>
            (O_RVALID && O_RDATA[HI_SER_FLG] == $past(I_EVENT.serial0_req));
    endproperty
    a_ser_ro: assert property (p_ser_ro) else $error("serial0 flag read wrong");

    property p_ser_type;
        (ser_exc && !ser_type_q) |-> O_EXC_REQ;
    endproperty
    a_ser_type: assert property (p_ser_type) else $error("ungated serial0 not requested");

    property p_no_ie;
        (!ie && !ser_exc) |-> (!O_EXC_REQ && O_SRC_ACCEPT == 3'h0);
    endproperty
    a_no_ie: assert property (p_no_ie) else $error("accepted with global enable off");

    property p_osc_write;
        (wr_lo && I_WDATA[LO_CLK_EN]) |=> O_OSC_DETECT_EN;
    endproperty
    a_osc_write: assert property (p_osc_write) else $error("detector not enabled");

    property p_flag_clear;
        (wr_lo && !I_WDATA[LO_ADR_FLG] && !set_adr) |=> !exc_lo_q[LO_ADR_FLG];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag survived clear");

    // a one written over a clear flag must not raise it
    property p_no_soft_set;
        (wr_lo && !exc_lo_q[LO_ODD_FLG] && !set_odd) |=> !exc_lo_q[LO_ODD_FLG];
    endproperty
    a_no_soft_set: assert property (p_no_soft_set) else $error("software set a flag");

    property p_hi_locked;
        (wr_hi_rq && !permit) |=>
            (ser_en_q == $past(ser_en_q) && ser_type_q == $past(ser_type_q));
    endproperty
    a_hi_locked: assert property (p_hi_locked) else $error("locked high write landed");

    property p_ser_masked;
        (ser_type_q && !ie) |-> !O_EXC_REQ;
    endproperty
    a_ser_masked: assert property (p_ser_masked) else $error("masked request raised");

    c_clk_stop: cover property (set_clk ##1 O_EXC_REQ);
    c_locked:   cover property (wr_lo_rq && !permit);
    c_race:     cover property (wr_lo && set_adr && !I_WDATA[LO_ADR_FLG]);
    c_irq:      cover property (O_IRQ ##[1:8] rd_stat);

endmodule
